/* File: rtl/rap_pkg.sv */
// Package with constants, types and register map of the relay alarm and pulse block.
package rap_pkg;

   // Channel and section counts.
   localparam int NUM_RELAY = 16;
   localparam int NUM_SECT = 4;
   localparam int RIDX_W = $clog2(NUM_RELAY);
   localparam int SIDX_W = $clog2(NUM_SECT);

   // Field widths.
   localparam int SECT_W = 3;
   localparam int FN_W = 3;
   localparam int DLY_W = 10;
   localparam int THR_W = 21;
   localparam int VAL_W = 32;
   localparam int VOL_W = 8;
   localparam int PEND_W = 16;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int PCNT_W = 20;

   // Register byte offsets.
   localparam logic [ADDR_W-1:0] ADR_STATUS = 12'h000;
   localparam logic [ADDR_W-1:0] ADR_MASK = 12'h004;
   localparam logic [ADDR_W-1:0] ADR_COIL = 12'h008;
   localparam logic [ADDR_W-1:0] ADR_CTRL = 12'h00C;
   localparam logic [ADDR_W-1:0] ADR_RELAY_BASE = 12'h100;
   localparam logic [ADDR_W-1:0] ADR_RELAY_END = 12'h180;
   localparam int RELAY_STRIDE_LSB = 3;
   localparam int RELAY_THR_BIT = 2;

   // Field positions inside the relay configuration word and the control word.
   localparam int CFG_SECT_LSB = 0;
   localparam int CFG_FN_LSB = 4;
   localparam int CFG_POL_BIT = 8;
   localparam int CFG_DLY_LSB = 16;
   localparam int CTRL_RUN_BIT = 0;

   // Limits of the threshold and the delay.
   localparam logic signed [VAL_W-1:0] THR_MAX = 32'sd999999;
   localparam logic signed [VAL_W-1:0] THR_MIN = -32'sd999999;
   localparam logic [DLY_W-1:0] DLY_MIN = 10'h001;
   localparam logic [DLY_W-1:0] DLY_MAX = 10'h3E7;

   // Totalizer pulse length: the same time is used for the gap between pulses.
   localparam int PULSE_TIME_NS = 50000000;
   localparam int CLK_PERIOD_NS = 50;
   localparam logic [PCNT_W-1:0] PULSE_CYC_DFLT = PCNT_W'(PULSE_TIME_NS / CLK_PERIOD_NS);

   // Relay function codes.
   typedef enum logic [FN_W-1:0] {
      relay_off_fn = 3'h0,
      section_flow_high_fn = 3'h1,
      section_level_high_fn = 3'h2,
      section_path_sub_fn = 3'h3,
      section_failure_alarm_fn = 3'h4,
      section_volume_pulse_fn = 3'h5,
      summed_flow_high_fn = 3'h6,
      summed_volume_pulse_fn = 3'h7
   } rap_fn_t;

   // Pulse generator states.
   typedef enum logic [2:0] {
      PLS_IDLE = 3'h1,
      PLS_ON = 3'h2,
      PLS_GAP = 3'h4
   } rap_pls_t;

   // One relay's configuration.
   typedef struct packed {
      logic [SECT_W-1:0] sect;
      rap_fn_t fn;
      logic pol;
      logic [DLY_W-1:0] dly;
      logic signed [THR_W-1:0] thr;
   } rap_cfg_t;

   // One section's measurement results.
   typedef struct packed {
      logic signed [VAL_W-1:0] flow;
      logic signed [VAL_W-1:0] level;
      logic failed;
      logic path_sub;
      logic [VOL_W-1:0] vol_units;
   } rap_sect_t;

   // Everything the measurement engine hands over per cycle.
   typedef struct packed {
      rap_sect_t [NUM_SECT-1:0] sect;
      logic signed [VAL_W-1:0] sum_flow;
      logic [VOL_W-1:0] summed_volume_pulse_fn_units;
      logic pipe_mode;
   } rap_meas_t;

   // State of one relay channel.
   typedef struct packed {
      logic active;
      logic [DLY_W-1:0] cnt;
      logic [PEND_W-1:0] pend;
      rap_pls_t pst;
      logic [PCNT_W-1:0] pcnt;
      logic coil;
   } rap_chan_st_t;

   // State of the register file and sequencing.
   typedef struct packed {
      rap_cfg_t [NUM_RELAY-1:0] cfg;
      logic [NUM_RELAY-1:0] status;
      logic [NUM_RELAY-1:0] mask;
      logic [NUM_RELAY-1:0] oper_d;
      logic run;
      logic armed;
      logic [DATA_W-1:0] rdata;
   } rap_top_st_t;

endpackage

/* File: rtl/rap_relay_chan.sv */
// One relay channel: condition, delay counting, pulse generation and coil polarity.
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module rap_relay_chan import rap_pkg::*; #(
   parameter logic [PCNT_W-1:0] PULSE_CYC = PULSE_CYC_DFLT
) (
   // Clock and reset.
   input wire logic i_core_clk,
   input wire logic i_nrst,
   // Configuration and measurement.
   input wire rap_cfg_t i_cfg,
   input wire rap_meas_t i_meas,
   input wire logic i_step,
   input wire logic i_run,
   // Relay drive.
   output logic o_coil,
   output logic o_operate
);

   rap_chan_st_t st_reg;
   rap_chan_st_t st_next;
   rap_sect_t sel;
   logic sect_ok;
   logic [SIDX_W-1:0] sidx;
   logic signed [VAL_W-1:0] thr_ext;
   logic [DLY_W-1:0] dly_eff;
   logic is_thr;
   logic is_alm;
   logic is_pls;
   logic cond;
   logic [VOL_W-1:0] units;
   logic [PEND_W:0] pend_sum;

   // Section pick; a section outside 1..NUM_SECT selects nothing.
   always_comb begin
      sect_ok = (i_cfg.sect != '0) && (i_cfg.sect <= SECT_W'(NUM_SECT)); // [R2]
      sidx = SIDX_W'(i_cfg.sect - SECT_W'(1));
      sel = i_meas.sect[sidx];
      thr_ext = {{(VAL_W-THR_W){i_cfg.thr[THR_W-1]}}, i_cfg.thr};
      dly_eff = (i_cfg.dly < DLY_MIN) ? DLY_MIN : i_cfg.dly; // [R13]
      if (dly_eff > DLY_MAX) begin
         dly_eff = DLY_MAX;
      end
   end

   // Function decode into threshold, alarm or pulse behaviour.
   always_comb begin
      is_thr = 1'b0;
      is_alm = 1'b0;
      is_pls = 1'b0;
      cond = 1'b0;
      units = '0;
      case (i_cfg.fn)
         section_flow_high_fn: begin
            is_thr = sect_ok;
            cond = sel.flow > thr_ext; // [R3] [R9]
         end
         section_level_high_fn: begin
            is_thr = sect_ok;
            cond = sel.level > thr_ext; // [R3] [R9]
         end
         section_path_sub_fn: begin
            is_alm = sect_ok;
            cond = sel.path_sub && i_meas.pipe_mode; // [R4]
         end
         section_failure_alarm_fn: begin
            is_alm = sect_ok;
            cond = sel.failed; // [R4]
         end
         section_volume_pulse_fn: begin
            is_pls = sect_ok;
            units = sel.vol_units; // [R5]
         end
         summed_flow_high_fn: begin
            is_thr = 1'b1;
            cond = i_meas.sum_flow > thr_ext; // [R7] [R9]
         end
         summed_volume_pulse_fn: begin
            is_pls = 1'b1;
            units = i_meas.summed_volume_pulse_fn_units; // [R8]
         end
         default: begin
            is_thr = 1'b0; // Unused relay stays idle. [R3]
         end
      endcase
   end

   // Next state: delay counting per measurement step, pulses per clock.
   always_comb begin
      st_next = st_reg;
      pend_sum = {1'b0, st_reg.pend};
      if (i_step && i_run) begin
         if (is_thr) begin
            // A crossing in either direction waits out the delay. [R10]
            if (cond == st_reg.active) begin
               st_next.cnt = '0;
            end else if (st_reg.cnt + DLY_W'(1) >= dly_eff) begin
               st_next.active = cond;
               st_next.cnt = '0;
            end else begin
               st_next.cnt = st_reg.cnt + DLY_W'(1);
            end
         end else if (is_alm) begin
            if (!cond) begin
               st_next.active = 1'b0; // [R12]
               st_next.cnt = '0;
            end else if (!st_reg.active) begin
               if (st_reg.cnt + DLY_W'(1) >= dly_eff) begin
                  st_next.active = 1'b1; // [R11]
                  st_next.cnt = '0;
               end else begin
                  st_next.cnt = st_reg.cnt + DLY_W'(1);
               end
            end
         end else begin
            st_next.active = 1'b0;
            st_next.cnt = '0;
         end
         if (is_pls) begin
            pend_sum = {1'b0, st_reg.pend} + (PEND_W+1)'(units);
         end
      end
      // Saturate rather than wrap so a burst never turns a large backlog into a small one.
      st_next.pend = pend_sum[PEND_W] ? '1 : pend_sum[PEND_W-1:0];
      if (!is_pls) begin
         st_next.pend = '0;
      end
      case (st_reg.pst)
         PLS_IDLE: begin
            if (is_pls && st_next.pend != '0) begin
               st_next.pend = st_next.pend - PEND_W'(1); // [R16]
               st_next.pst = PLS_ON;
               st_next.pcnt = PULSE_CYC - PCNT_W'(1);
            end
         end
         PLS_ON: begin
            if (st_reg.pcnt == '0) begin
               st_next.pst = PLS_GAP; // A gap keeps pulses apart. [R16]
               st_next.pcnt = PULSE_CYC - PCNT_W'(1);
            end else begin
               st_next.pcnt = st_reg.pcnt - PCNT_W'(1);
            end
         end
         PLS_GAP: begin
            if (st_reg.pcnt == '0) begin
               st_next.pst = PLS_IDLE;
            end else begin
               st_next.pcnt = st_reg.pcnt - PCNT_W'(1);
            end
         end
         default: begin
            st_next.pst = PLS_IDLE;
         end
      endcase
      st_next.coil = (is_pls ? (st_next.pst == PLS_ON) : st_next.active) ^ i_cfg.pol; // [R14]
      if (!i_run) begin
         st_next = '0; // [R15]
         st_next.pst = PLS_IDLE;
      end
   end

   // State register.
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_reg <= '0; // [R15]
         st_reg.pst <= PLS_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_coil = st_reg.coil;
   assign o_operate = is_pls ? (st_reg.pst == PLS_ON) : st_reg.active;

endmodule

/* File: rtl/rap_relay_top.sv */
// Relay alarm and totalizer pulse controller with its register file.
`timescale 1ns/1ps

// Operation
// R1: Sixteen relays, each with own configuration.
// R2: Section select; zero means sum of sections. Here zero selects nothing; codes 6 and 7 use the sum for any section.
// R3: Code 0 off, 1 flow, 2 level high.
// R4: Code 3 path substitution (pipe), 4 failure.
// R5: Code 5 pulses section volume totalizer.
// R6: Software assigns one section pulse relay per section.
// R7: Code 6 summed flow above threshold.
// R8: Code 7 pulses summed volume totalizer.
// R9: Signed threshold limited to plus/minus 999999.
// R10: Threshold change waits configured delay cycles.
// R11: Alarm operates after delay from onset.
// R12: Alarm end releases relay at once.
// R13: Delay range 1 to 999 cycles.
// R14: Polarity 1 inverts coil energizing.
// R15: Coils off until configured and first step.
// R16: One fixed pulse per unit, never overlapping.
module rap_relay_top import rap_pkg::*; #(
   parameter logic [PCNT_W-1:0] PULSE_CYC = PULSE_CYC_DFLT
) (
   // Clock and reset.
   input wire logic i_core_clk,
   input wire logic i_nrst,
   // Register port.
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [DATA_W-1:0] o_rdata,
   // Measurement engine.
   input wire logic i_meas_step,
   input wire rap_meas_t i_meas,
   // Relay coils and interrupt.
   output logic [NUM_RELAY-1:0] o_coil,
   output logic o_irq
);

   rap_top_st_t st_reg;
   rap_top_st_t st_next;
   logic [NUM_RELAY-1:0] oper;
   logic [NUM_RELAY-1:0] events;
   logic [NUM_RELAY-1:0] rd_clr;
   logic in_relay;
   logic [ADDR_W-1:0] roff;
   logic [RIDX_W-1:0] ridx;
   logic is_thr_word;
   logic signed [VAL_W-1:0] wval;
   logic [DLY_W-1:0] wdly;
   rap_cfg_t rcfg;

   // One channel per relay, each reading only its own configuration.
   genvar g;
   generate
      for (g = 0; g < NUM_RELAY; g = g + 1) begin : g_chan
         rap_relay_chan #(
            .PULSE_CYC(PULSE_CYC)
         ) u_chan (
            .i_core_clk(i_core_clk),
            .i_nrst(i_nrst),
            .i_cfg(st_reg.cfg[g]),
            .i_meas(i_meas),
            .i_step(i_meas_step),
            .i_run(st_reg.armed),
            .o_coil(o_coil[g]),
            .o_operate(oper[g])
         ); // [R1]
      end
   endgenerate

   // Relay window decode: two aligned words per relay.
   always_comb begin
      roff = i_addr - ADR_RELAY_BASE;
      ridx = roff[RELAY_STRIDE_LSB +: RIDX_W];
      is_thr_word = roff[RELAY_THR_BIT];
      in_relay = (i_addr >= ADR_RELAY_BASE) && (i_addr < ADR_RELAY_END) && (i_addr[1:0] == 2'h0);
      rcfg = st_reg.cfg[ridx];
   end

   // Write data shaping: clamp the threshold and the delay into their ranges.
   always_comb begin
      wval = $signed(i_wdata);
      if (wval > THR_MAX) begin
         wval = THR_MAX; // [R9]
      end else if (wval < THR_MIN) begin
         wval = THR_MIN; // [R9]
      end
      wdly = i_wdata[CFG_DLY_LSB +: DLY_W];
      if (wdly < DLY_MIN) begin
         wdly = DLY_MIN; // [R13]
      end else if (wdly > DLY_MAX) begin
         wdly = DLY_MAX; // [R13]
      end
   end

   // Events: every rise of a relay's operate state, including each pulse start.
   assign events = oper & ~st_reg.oper_d;

   // Register file, read port and interrupt status.
   always_comb begin
      st_next = st_reg;
      st_next.oper_d = oper;
      st_next.rdata = '0;
      rd_clr = '0;
      // Writes.
      if (i_wr) begin
         if (i_addr == ADR_MASK) begin
            st_next.mask = i_wdata[NUM_RELAY-1:0];
         end else if (i_addr == ADR_CTRL) begin
            st_next.run = i_wdata[CTRL_RUN_BIT];
         end else if (in_relay && is_thr_word) begin
            st_next.cfg[ridx].thr = wval[THR_W-1:0];
         end else if (in_relay) begin
            st_next.cfg[ridx].sect = i_wdata[CFG_SECT_LSB +: SECT_W]; // [R2]
            st_next.cfg[ridx].fn = rap_fn_t'(i_wdata[CFG_FN_LSB +: FN_W]);
            st_next.cfg[ridx].pol = i_wdata[CFG_POL_BIT]; // [R14]
            st_next.cfg[ridx].dly = wdly;
         end
      end
      // Reads; unmapped addresses answer zero.
      if (i_rd) begin
         if (i_addr == ADR_STATUS) begin
            st_next.rdata = DATA_W'(st_reg.status);
            rd_clr = st_reg.status;
         end else if (i_addr == ADR_MASK) begin
            st_next.rdata = DATA_W'(st_reg.mask);
         end else if (i_addr == ADR_COIL) begin
            st_next.rdata = DATA_W'(o_coil);
         end else if (i_addr == ADR_CTRL) begin
            st_next.rdata = DATA_W'({st_reg.armed, st_reg.run});
         end else if (in_relay && is_thr_word) begin
            st_next.rdata = {{(DATA_W-THR_W){rcfg.thr[THR_W-1]}}, rcfg.thr};
         end else if (in_relay) begin
            st_next.rdata[CFG_SECT_LSB +: SECT_W] = rcfg.sect;
            st_next.rdata[CFG_FN_LSB +: FN_W] = rcfg.fn;
            st_next.rdata[CFG_POL_BIT] = rcfg.pol;
            st_next.rdata[CFG_DLY_LSB +: DLY_W] = rcfg.dly;
         end
      end
      // A new event in the clearing read cycle survives: set wins.
      st_next.status = (st_reg.status & ~rd_clr) | events;
      // Relays start only after software enables them and one step has completed.
      if (!st_reg.run) begin
         st_next.armed = 1'b0; // [R15]
      end else if (i_meas_step) begin
         st_next.armed = 1'b1; // [R15]
      end
   end

   // State register; all configuration comes up as unused relays.
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_reg <= '0; // [R15]
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_rdata = st_reg.rdata;
   assign o_irq = |(st_reg.status & st_reg.mask);

endmodule

/* File: verif/rap_coil_load.sv */
// Model of the relay coils: counts energize events and run lengths.
`timescale 1ns/1ps
module rap_coil_load import rap_pkg::*; (
   // Clock and reset.
   input wire logic i_core_clk,
   input wire logic i_nrst,
   // Coil drive and observations.
   input wire logic [NUM_RELAY-1:0] i_coil,
   output logic [7:0] o_rise_cnt [NUM_RELAY],
   output logic [7:0] o_hi_len [NUM_RELAY],
   output logic [7:0] o_gap_len [NUM_RELAY]
);
   logic [NUM_RELAY-1:0] prev_reg;
   logic [7:0] run_reg [NUM_RELAY];
   // Run lengths saturate, so a long idle level cannot wrap into a short one.
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         prev_reg <= '0;
         for (int n = 0; n < NUM_RELAY; n++) begin
            run_reg[n] <= 8'h00;
            o_rise_cnt[n] <= 8'h00;
            o_hi_len[n] <= 8'h00;
            o_gap_len[n] <= 8'h00;
         end
      end else begin
         prev_reg <= i_coil;
         for (int n = 0; n < NUM_RELAY; n++) begin
            if (i_coil[n] != prev_reg[n]) begin
               run_reg[n] <= 8'h01;
               if (i_coil[n]) begin
                  o_rise_cnt[n] <= o_rise_cnt[n] + 8'h01;
                  o_gap_len[n] <= run_reg[n];
               end else begin
                  o_hi_len[n] <= run_reg[n];
               end
            end else if (run_reg[n] != 8'hFF) begin
               run_reg[n] <= run_reg[n] + 8'h01;
            end
         end
      end
   end
endmodule

/* File: verif/rap_relay_props.sv */
// Port-level assertions of the relay alarm and pulse controller.
`timescale 1ns/1ps
module rap_relay_props import rap_pkg::*; #(
   parameter logic [PCNT_W-1:0] PULSE_CYC = PULSE_CYC_DFLT
) (
   // Clock and reset.
   input wire logic i_core_clk,
   input wire logic i_nrst,
   // Register port.
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [DATA_W-1:0] o_rdata,
   // Measurement, coils and interrupt.
   input wire logic i_meas_step,
   input wire rap_meas_t i_meas,
   input wire logic [NUM_RELAY-1:0] o_coil,
   input wire logic o_irq
);
   logic seen_reg;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);
   // Remembers the first step, before which no coil may be energized.
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         seen_reg <= 1'b0;
      end else if (i_meas_step) begin
         seen_reg <= 1'b1;
      end
   end
   // A write of a configuration word followed at once by its read.
   sequence s_cfg_wr;
      i_wr && i_addr inside {[ADR_RELAY_BASE:ADR_RELAY_END-1]} && i_addr[2:0] == 3'h0;
   endsequence
   sequence s_same_rd;
      i_rd && i_addr == $past(i_addr);
   endsequence
   chk_cfg_keep: assert property (s_cfg_wr ##1 s_same_rd |=>
      (o_rdata & 32'h177) == ($past(i_wdata, 2) & 32'h177)) else $error("config lost");
   chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == '0)
      else $error("read data outside slot");
   chk_unmapped_zero: assert property ($past(i_rd) && $past(i_addr) >= ADR_RELAY_END
      |-> o_rdata == '0) else $error("unmapped read not zero");
   chk_thr_clamp: assert property ($past(i_rd) && $past(i_addr[2]) &&
      $past(i_addr) inside {[ADR_RELAY_BASE:ADR_RELAY_END-1]}
      |-> $signed(o_rdata) <= THR_MAX && $signed(o_rdata) >= THR_MIN) else $error("thr range");
   chk_dly_range: assert property ($past(i_rd) && !$past(i_addr[2]) &&
      $past(i_addr) inside {[ADR_RELAY_BASE:ADR_RELAY_END-1]} && o_rdata[6:4] != 3'h0
      |-> o_rdata[25:16] inside {[DLY_MIN:DLY_MAX]}) else $error("delay range");
   chk_coil_early: assert property (!seen_reg |-> o_coil == '0)
      else $error("coil before first step");
   chk_ctrl_stop: assert property (i_wr && i_addr == ADR_CTRL && !i_wdata[CTRL_RUN_BIT]
      |-> ##[1:3] o_coil == '0) else $error("coil after stop");
   chk_mask_off: assert property (i_wr && i_addr == ADR_MASK && i_wdata[15:0] == 16'h0
      |=> !o_irq) else $error("irq while masked");
   chk_coil_read: assert property ($past(i_rd) && $past(i_addr) == ADR_COIL
      |-> o_rdata == {16'h0, $past(o_coil)}) else $error("coil readback");
endmodule
bind rap_relay_top rap_relay_props #(.PULSE_CYC(PULSE_CYC)) u_props (.i_core_clk(i_core_clk),
   .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
   .o_rdata(o_rdata), .i_meas_step(i_meas_step), .i_meas(i_meas), .o_coil(o_coil),
   .o_irq(o_irq));

/* File: verif/tb_rap_relay_top.sv */
// Self-checking testbench of the relay alarm and pulse controller.
`timescale 1ns/1ps
module tb_rap_relay_top import rap_pkg::*; ;
   localparam logic [PCNT_W-1:0] PC = 20'h00004;
   localparam logic [ADDR_W-1:0] RB = ADR_RELAY_BASE;
   logic clk, nrst, wr, rd, step, irq;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wd, rdat, d;
   logic [NUM_RELAY-1:0] coil;
   logic [7:0] rc [NUM_RELAY], hl [NUM_RELAY], gl [NUM_RELAY];
   rap_meas_t m;
   logic [31:0] lf;
   logic signed [31:0] t, lv;
   int errors, check_count;
   rap_relay_top #(.PULSE_CYC(PC)) dut (.i_core_clk(clk), .i_nrst(nrst), .i_addr(addr),
      .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdat), .i_meas_step(step), .i_meas(m),
      .o_coil(coil), .o_irq(irq));
   rap_coil_load coils (.i_core_clk(clk), .i_nrst(nrst), .i_coil(coil), .o_rise_cnt(rc),
      .o_hi_len(hl), .o_gap_len(gl));
   // Free-running core clock.
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Next value of the stimulus sequence.
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Random threshold kept inside the legal range.
   function automatic logic signed [31:0] rthr(input logic [31:0] s);
      return $signed({12'h000, s[19:0]}) - 32'sd500000;
   endfunction
   task automatic conclude();
      if (errors == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic cmp(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("BAD %0t got %h expected %h", $time, g, e);
      end
   endtask
   // Bus tasks start just after a rising edge, so calls may follow with no gap.
   // The write strobe stays up across back-to-back writes; the next task or caller lowers it.
   task automatic wrr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
      addr <= a;
      wd <= v;
      wr <= 1'b1;
      @(posedge clk);
   endtask
   task automatic rdd(input logic [ADDR_W-1:0] a);
      addr <= a;
      rd <= 1'b1;
      wr <= 1'b0;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      d = rdat;
   endtask
   task automatic cf(input int n, input logic [2:0] s, input logic [2:0] f, input logic p,
      input logic [9:0] dl, input logic [31:0] th);
      wrr(RB + ADDR_W'(8 * n), {6'h00, dl, 7'h00, p, 1'b0, f, 1'b0, s});
      wrr(RB + ADDR_W'(8 * n + 4), th);
   endtask
   task automatic pulse();
      step <= 1'b1;
      wr <= 1'b0;
      @(posedge clk);
      step <= 1'b0;
   endtask
   // One measurement step, then the coils are compared once they have settled.
   task automatic stp(input logic [NUM_RELAY-1:0] e);
      pulse();
      repeat (2) @(posedge clk);
      cmp({16'h0000, coil}, {16'h0000, e});
   endtask
   // Watchdog sized at about fourteen times the expected run.
   initial begin
      #100000;
      errors++;
      conclude();
   end
   // Main sequence.
   initial begin
      nrst = 1'b0; wr = 1'b0; rd = 1'b0; step = 1'b0; addr = '0; wd = '0; m = '0;
      errors = 0; check_count = 0; lf = lfsr(32'h0F86); t = rthr(lf); lf = lfsr(lf);
      lv = rthr(lf);
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      cmp({15'h0000, irq, coil}, 32'h0);
      rdd(ADR_MASK);
      cmp(d, 32'h0);
      m.sum_flow <= -32'sd5; m.sect[1].flow <= t; m.sect[3].level <= lv;
      cf(0, 3'h1, section_failure_alarm_fn, 1'b0, 10'h003, 32'h0);
      cf(1, 3'h2, section_flow_high_fn, 1'b0, 10'h002, t);
      cf(2, 3'h0, summed_flow_high_fn, 1'b1, 10'h001, -32'sd5);
      cf(3, 3'h0, summed_volume_pulse_fn, 1'b0, 10'h001, 32'h0);
      cf(4, 3'h3, section_volume_pulse_fn, 1'b0, 10'h001, 32'h0);
      cf(5, 3'h0, section_volume_pulse_fn, 1'b0, 10'h001, 32'h0);
      cf(6, 3'h4, section_level_high_fn, 1'b0, 10'h001, lv);
      cf(7, 3'h1, section_path_sub_fn, 1'b0, 10'h001, 32'h0);
      cf(8, 3'h0, relay_off_fn, 1'b1, 10'h001, 32'h0);
      cf(9, 3'h0, relay_off_fn, 1'b0, 10'h000, 32'd2000000);
      rdd(RB + 12'h048);
      cmp(d, 32'h00010000);
      rdd(RB + 12'h04C);
      cmp(d, 32'd999999);
      cf(9, 3'h0, relay_off_fn, 1'b0, 10'h3E8, -32'sd2000000);
      rdd(RB + 12'h048);
      cmp(d, 32'h03E70000);
      rdd(RB + 12'h04C);
      cmp(d, -32'sd999999);
      wrr(RB + 12'h050, 32'h00050035);
      rdd(RB + 12'h050);
      cmp(d, 32'h00050035);
      rdd(12'h200);
      cmp(d, 32'h0);
      stp(16'h0000);
      wrr(ADR_CTRL, 32'h1);
      pulse();
      rdd(ADR_CTRL);
      cmp(d, 32'h3);
      wrr(ADR_MASK, 32'h1);
      rdd(ADR_STATUS);
      stp(16'h0104);
      m.sect[0].failed <= 1'b1; m.sect[1].flow <= t + 1; m.sect[3].level <= lv + 1;
      m.sum_flow <= -32'sd4;
      stp(16'h0140);
      stp(16'h0142);
      stp(16'h0143);
      cmp({31'h0, irq}, 32'h1);
      rdd(ADR_STATUS);
      cmp(d, 32'h47);
      cmp({31'h0, irq}, 32'h0);
      rdd(ADR_COIL);
      cmp(d, 32'h0143);
      m.sect[0].failed <= 1'b0; m.sect[1].flow <= t; m.sect[0].path_sub <= 1'b1;
      stp(16'h0142);
      m.pipe_mode <= 1'b1;
      stp(16'h01C0);
      cmp({31'h0, irq}, 32'h0);
      m.sect[0].failed <= 1'b1; m.sect[0].path_sub <= 1'b0; m.sect[3].level <= lv;
      stp(16'h0100);
      m.sect[0].failed <= 1'b0; m.sum_flow <= -32'sd5;
      stp(16'h0104);
      m.summed_volume_pulse_fn_units <= 8'h02; m.sect[2].vol_units <= 8'h01; m.sect[0].vol_units <= 8'h01;
      pulse();
      m.summed_volume_pulse_fn_units <= 8'h00; m.sect[2].vol_units <= 8'h00; m.sect[0].vol_units <= 8'h00;
      repeat (40) @(posedge clk);
      cmp({8'h00, rc[3], rc[4], rc[5]}, 32'h00020100);
      cmp({24'h0, hl[3]}, {12'h0, PC});
      cmp({31'h0, gl[3] >= PC[7:0]}, 32'h1);
      cmp({16'h0000, coil}, 32'h0104);
      wrr(ADR_MASK, 32'hFFFF);
      wr <= 1'b0;
      @(posedge clk);
      cmp({31'h0, irq}, 32'h1);
      wrr(ADR_MASK, 32'h0);
      wr <= 1'b0;
      @(posedge clk);
      cmp({31'h0, irq}, 32'h0);
      wrr(ADR_CTRL, 32'h0);
      wr <= 1'b0;
      // Stop takes three edges: run clears, then armed, then the channel state.
      repeat (3) @(posedge clk);
      cmp({16'h0000, coil}, 32'h0);
      conclude();
   end
endmodule
